// file: common/svbk_regs.svh
// Purpose: offsets, field positions and reset values of the bank-one
//          configuration register file
// Assumes: byte-wide registers at their printed offsets
// Notes: definitions only
`ifndef SVBK_REGS_SVH
`define SVBK_REGS_SVH

// ==========================================================
// offsets
`define SVBK_OFF_MON_CTL 8'h10
`define SVBK_OFF_MISC 8'h11
`define SVBK_OFF_TEST 8'h12
`define SVBK_OFF_IEN_UVF 8'h13
`define SVBK_OFF_IEN_UVS 8'h14
`define SVBK_OFF_CH3_CUT 8'h45
`define SVBK_OFF_CH4_UVF 8'h50
`define SVBK_OFF_CH4_OVF 8'h51
`define SVBK_OFF_CH4_UVS 8'h52
`define SVBK_OFF_CH4_OVS 8'h53
`define SVBK_OFF_CH4_DEB 8'h54
`define SVBK_OFF_CH4_CUT 8'h55
`define SVBK_OFF_ESM_TIME 8'h9E
`define SVBK_OFF_SAFETY 8'h9F
`define SVBK_OFF_SUPPLY_TRANSITION_MASK_UP 8'hA1
`define SVBK_OFF_SUPPLY_TRANSITION_MASK_DN 8'hA2
`define SVBK_OFF_TOUT_HI 8'hA5
`define SVBK_OFF_TOUT_LO 8'hA6
`define SVBK_OFF_UP_THLD 8'hA8
`define SVBK_OFF_DN_THLD 8'hA9
`define SVBK_OFF_WATCHDOG_VIOLATION_CONFIG 8'hAA
`define SVBK_OFF_WATCHDOG_CLOSED_WINDOW_TIME 8'hAB
`define SVBK_OFF_WATCHDOG_OPEN_WINDOW_TIME 8'hAC
`define SVBK_OFF_WDT_QA 8'hAD
`define SVBK_OFF_WDT_REPLY 8'hAE
`define SVBK_OFF_PAGE_SEL 8'hF0

// ==========================================================
// field positions
`define SVBK_BIT_FORCE_WDO 4
`define SVBK_BIT_RESET_PROT 3
`define SVBK_BIT_FORCE_IRQ 0
`define SVBK_BIT_PEC_REQ 1
`define SVBK_BIT_PEC_EN 0
`define SVBK_BIT_ST_SHDN 2
`define SVBK_BIT_ST_POR1 1
`define SVBK_BIT_ST_POR0 0
`define SVBK_DLY_HI 6
`define SVBK_DLY_LO 4
`define SVBK_CH_HI 3
`define SVBK_CH_LO 1

// ==========================================================
// reset values
`define SVBK_RST_MON_CTL 8'h20
`define SVBK_RST_OTHER 8'h00

`endif

// file: common/svbk_pkg.sv
// Purpose: shared types of the bank-one register file
// Assumes: nothing
// Notes: offsets live in svbk_regs.svh
`default_nettype none
package svbk_pkg;
  typedef logic [7:0] svbk_byte_t;
  typedef logic [2:0] svbk_chmask_t;
endpackage
`default_nettype wire

// file: hw/svbk_bank1_regs.sv
// Purpose: bank-one configuration register file of a voltage supervisor
// Assumes: host bytes arrive as single-cycle write / read strobes,
//          already decoded from the two-wire bus
// Notes: analog and watchdog engines sit outside and read the config
//        outputs; this file stores, forces, gates the masks and raises one-shot events
`timescale 1ns/10ps
`default_nettype none
`include "svbk_regs.svh"

// Operation
// - force-watchdog bit 4 holds the watchdog fault output low while set.
// - force-interrupt bit 0 holds the interrupt output low while set.
// - control bit 3 reads zero; writing one clears the protection registers.
// - watchdog delay field bits 6-4 ignored when watchdog output is latched.
// - misc bit 1 set demands a packet check byte on transactions.
// - misc bit 0 enables packet error checking.
// - self-test bit 2 runs built-in self test on entering shutdown.
// - self-test bits 1 and 0 request power-on test; bit 1 is redundant copy.
// - fast undervoltage enables: bits 3,2,1 for channels 4,3,2.
// - slow undervoltage enables: bits 3,2,1 for channels 4,3,2.
// - control register resets to 20h, reserved bits 7-5 at 1h.
// - per-channel slow cutoff register sets the filter -3 dB point.
// - per-channel debounce register filters fast comparator outputs.
// - power-up auto-mask picks channels suppressed while ramping up.
// - power-down auto-mask picks channels suppressed while ramping down.
// - power-up mask released when voltage crosses power-up threshold.
// - power-down mask released when voltage crosses power-down threshold.
// - two-byte sequence timeout bounds tolerated undervoltage in ramps.
// - watchdog config holds violation count and start-up multiplier.
// - error-signal register holds persistence time before a fault.
module svbk_bank1_regs (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // register access from the serial bus
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  // fault sources and status from the monitor core
  input wire logic wdog_fault_in,
  input wire logic wdog_latched_in,
  input wire logic irq_req_in,
  input wire logic shutdown_in,
  input wire logic por_done_in,
  input wire logic [2:0] ramp_up_in,
  input wire logic [2:0] ramp_down_in,
  input wire logic [2:0] above_up_thld_in,
  input wire logic [2:0] below_dn_thld_in,
  // pins (active low)
  output logic watchdog_fault_out_n,
  output logic interrupt_out_n,
  // configuration to the monitor core
  output logic [2:0] watchdog_fault_hold_delay,
  output logic packet_check_enable,
  output logic packet_check_required,
  output logic protect_clear_out,
  output logic self_test_start_out,
  output logic [2:0] fast_uv_irq_en_out,
  output logic [2:0] slow_uv_irq_en_out,
  output logic [2:0] supply_transition_mask,
  output logic [15:0] seq_timeout_out,
  output logic [7:0] ch3_cutoff_out,
  output logic [7:0] ch4_cutoff_out,
  output logic [7:0] ch4_debounce_out,
  output logic [7:0] watchdog_violation_config_out,
  output logic [7:0] esm_time_out
);

  // ==========================================================
  // storage
  // a full 256-entry array keeps decode simple; unmapped slots are
  // never written, so they stay zero and synthesis trims them
  svbk_pkg::svbk_byte_t mon_ctl_q, misc_q, test_q, ien_uvf_q, ien_uvs_q;
  svbk_pkg::svbk_byte_t regs_q [0:255];
  svbk_pkg::svbk_byte_t rd_d;
  logic mapped_d;
  logic shdn_q;
  logic por_q;
  logic por_seen_q;

  function automatic logic is_generic(input logic [7:0] a);
    is_generic = (a == `SVBK_OFF_CH3_CUT) ||
                 (a >= `SVBK_OFF_CH4_UVF && a <= `SVBK_OFF_CH4_CUT) ||
                 (a == `SVBK_OFF_ESM_TIME) || (a == `SVBK_OFF_SAFETY) ||
                 (a == `SVBK_OFF_SUPPLY_TRANSITION_MASK_UP) || (a == `SVBK_OFF_SUPPLY_TRANSITION_MASK_DN) ||
                 (a == `SVBK_OFF_TOUT_HI) || (a == `SVBK_OFF_TOUT_LO) ||
                 (a >= `SVBK_OFF_UP_THLD && a <= `SVBK_OFF_WDT_REPLY) ||
                 (a == `SVBK_OFF_PAGE_SEL);
  endfunction

  // ==========================================================
  // dedicated control registers
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      mon_ctl_q <= `SVBK_RST_MON_CTL;
    end
    else if (wr_en_in && addr_in == `SVBK_OFF_MON_CTL)
    begin
      mon_ctl_q <= wdata_in;
      mon_ctl_q[`SVBK_BIT_RESET_PROT] <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      misc_q <= `SVBK_RST_OTHER;
      test_q <= `SVBK_RST_OTHER;
      ien_uvf_q <= `SVBK_RST_OTHER;
      ien_uvs_q <= `SVBK_RST_OTHER;
    end
    else if (wr_en_in)
    begin
      // reserved bits keep the written value but drive nothing
      if (addr_in == `SVBK_OFF_MISC)
      begin
        misc_q <= wdata_in;
      end
      else if (addr_in == `SVBK_OFF_TEST)
      begin
        test_q <= wdata_in;
      end
      else if (addr_in == `SVBK_OFF_IEN_UVF)
      begin
        ien_uvf_q <= wdata_in;
      end
      else if (addr_in == `SVBK_OFF_IEN_UVS)
      begin
        ien_uvs_q <= wdata_in;
      end
    end
  end

  // thresholds, filters, sequencing, watchdog and error-monitor bytes
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      for (int i = 0; i < 256; i++)
      begin
        regs_q[i] <= `SVBK_RST_OTHER;
      end
    end
    else if (wr_en_in && is_generic(addr_in))
    begin
      regs_q[addr_in] <= wdata_in;
    end
  end

  // ==========================================================
  // read path; unmapped offsets read zero
  // data is registered so it stands one cycle beside rvalid_out
  always_comb
  begin
    rd_d = 8'h00;
    mapped_d = 1'b1;
    if (addr_in == `SVBK_OFF_MON_CTL)
    begin
      rd_d = mon_ctl_q;
      rd_d[`SVBK_BIT_RESET_PROT] = 1'b0;
    end
    else if (addr_in == `SVBK_OFF_MISC)
    begin
      rd_d = misc_q;
    end
    else if (addr_in == `SVBK_OFF_TEST)
    begin
      rd_d = test_q;
    end
    else if (addr_in == `SVBK_OFF_IEN_UVF)
    begin
      rd_d = ien_uvf_q;
    end
    else if (addr_in == `SVBK_OFF_IEN_UVS)
    begin
      rd_d = ien_uvs_q;
    end
    else if (is_generic(addr_in))
    begin
      rd_d = regs_q[addr_in];
    end
    else
    begin
      mapped_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      rdata_out <= 8'h00;
      rvalid_out <= 1'b0;
    end
    else
    begin
      rdata_out <= (rd_en_in && mapped_d) ? rd_d : 8'h00;
      rvalid_out <= rd_en_in;
    end
  end

  // ==========================================================
  // output pins
  // force bits add to the core request, they never mask a real fault
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      watchdog_fault_out_n <= 1'b1;
      interrupt_out_n <= 1'b1;
    end
    else
    begin
      watchdog_fault_out_n <= ~(wdog_fault_in |
                               mon_ctl_q[`SVBK_BIT_FORCE_WDO]);
      interrupt_out_n <= ~(irq_req_in |
                          mon_ctl_q[`SVBK_BIT_FORCE_IRQ]);
    end
  end

  // ==========================================================
  // one-shot events: protection clear and self-test start
  // edge detectors reset to the idle low level of both inputs,
  // so leaving reset never looks like a rising edge
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      protect_clear_out <= 1'b0;
      self_test_start_out <= 1'b0;
      shdn_q <= 1'b0;
      por_q <= 1'b0;
      por_seen_q <= 1'b0;
    end
    else
    begin
      protect_clear_out <= wr_en_in && addr_in == `SVBK_OFF_MON_CTL &&
                           wdata_in[`SVBK_BIT_RESET_PROT];
      shdn_q <= shutdown_in;
      por_q <= por_done_in;
      // either power-on copy suffices, the second covers a flipped bit
      self_test_start_out <=
        (shutdown_in && !shdn_q && test_q[`SVBK_BIT_ST_SHDN]) ||
        (por_done_in && !por_q && !por_seen_q &&
         (test_q[`SVBK_BIT_ST_POR0] | test_q[`SVBK_BIT_ST_POR1]));
      if (por_done_in)
      begin
        por_seen_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // configuration outputs
  // outputs trail the stored byte by one cycle; seq_timeout_out joins two
  // separately written registers, so the core can see a torn value there
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      watchdog_fault_hold_delay <= 3'h0;
      packet_check_enable <= 1'b0;
      packet_check_required <= 1'b0;
      fast_uv_irq_en_out <= 3'h0;
      slow_uv_irq_en_out <= 3'h0;
      supply_transition_mask <= 3'h0;
      seq_timeout_out <= 16'h0000;
      ch3_cutoff_out <= 8'h00;
      ch4_cutoff_out <= 8'h00;
      ch4_debounce_out <= 8'h00;
      watchdog_violation_config_out <= 8'h00;
      esm_time_out <= 8'h00;
    end
    else
    begin
      // latched watchdog output has no hold time
      watchdog_fault_hold_delay <= wdog_latched_in ? 3'h0 :
        misc_q[`SVBK_DLY_HI:`SVBK_DLY_LO];
      packet_check_required <= misc_q[`SVBK_BIT_PEC_REQ];
      packet_check_enable <= misc_q[`SVBK_BIT_PEC_EN];
      fast_uv_irq_en_out <= ien_uvf_q[`SVBK_CH_HI:`SVBK_CH_LO];
      slow_uv_irq_en_out <= ien_uvs_q[`SVBK_CH_HI:`SVBK_CH_LO];
      // mask holds while ramping until the release threshold is crossed
      supply_transition_mask <=
        (regs_q[`SVBK_OFF_SUPPLY_TRANSITION_MASK_UP][`SVBK_CH_HI:`SVBK_CH_LO] &
         ramp_up_in & ~above_up_thld_in) |
        (regs_q[`SVBK_OFF_SUPPLY_TRANSITION_MASK_DN][`SVBK_CH_HI:`SVBK_CH_LO] &
         ramp_down_in & ~below_dn_thld_in);
      seq_timeout_out <= {regs_q[`SVBK_OFF_TOUT_HI],
                          regs_q[`SVBK_OFF_TOUT_LO]};
      ch3_cutoff_out <= regs_q[`SVBK_OFF_CH3_CUT];
      ch4_cutoff_out <= regs_q[`SVBK_OFF_CH4_CUT];
      ch4_debounce_out <= regs_q[`SVBK_OFF_CH4_DEB];
      watchdog_violation_config_out <= regs_q[`SVBK_OFF_WATCHDOG_VIOLATION_CONFIG];
      esm_time_out <= regs_q[`SVBK_OFF_ESM_TIME];
    end
  end

endmodule
`default_nettype wire

// file: tb/svbk_bank1_chk.sv
// Purpose: port checks of the bank-one register file
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every svbk_bank1_regs instance
`timescale 1ns/10ps
`default_nettype none
module svbk_bank1_chk (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // host access
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rdata_out,
  // core status, pins and config
  input wire logic wdog_latched_in,
  input wire logic watchdog_fault_out_n,
  input wire logic interrupt_out_n,
  input wire logic [2:0] watchdog_fault_hold_delay,
  input wire logic packet_check_enable,
  input wire logic packet_check_required,
  input wire logic protect_clear_out,
  input wire logic [2:0] fast_uv_irq_en_out
);
  logic cw, mw, fw, clr;
  logic [1:0] pb;
  logic [2:0] ub;
  assign cw = wr_en_in && addr_in == 8'h10;
  assign mw = wr_en_in && addr_in == 8'h11;
  assign fw = wr_en_in && addr_in == 8'h13;
  assign clr = cw && wdata_in[3];
  assign pb = wdata_in[1:0];
  assign ub = wdata_in[3:1];
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);
  a_force_wdog_pin: assert property (
    cw && wdata_in[4] ##1 !cw |-> ##1 !watchdog_fault_out_n)
    else $error("watchdog pin not forced low");
  a_force_irq_pin: assert property (
    cw && wdata_in[0] ##1 !cw |-> ##1 !interrupt_out_n)
    else $error("interrupt pin not forced low");
  a_clear_pulse_follows: assert property (clr |=> protect_clear_out)
    else $error("protect clear pulse missing");
  a_clear_has_cause: assert property (
    protect_clear_out |-> $past(clr))
    else $error("protect clear pulse without write");
  a_clear_bit_zero: assert property (
    rd_en_in && addr_in == 8'h10 |=> !rdata_out[3])
    else $error("control bit 3 read as one");
  a_pec_bits_map: assert property (
    mw ##1 !mw |-> ##1
    {packet_check_required, packet_check_enable} == $past(pb, 2))
    else $error("packet check outputs wrong");
  a_latched_no_delay: assert property (
    wdog_latched_in [*2] |-> watchdog_fault_hold_delay == 3'h0)
    else $error("hold delay active while latched");
  a_uv_enable_map: assert property (
    fw ##1 !fw |-> ##1 fast_uv_irq_en_out == $past(ub, 2))
    else $error("fast undervoltage enables wrong");
endmodule
bind svbk_bank1_regs svbk_bank1_chk chk_i (.mclk_in, .sys_rst_in,
  .wr_en_in, .rd_en_in, .addr_in, .wdata_in, .rdata_out,
  .wdog_latched_in, .watchdog_fault_out_n, .interrupt_out_n,
  .watchdog_fault_hold_delay, .packet_check_enable,
  .packet_check_required, .protect_clear_out, .fast_uv_irq_en_out);
`default_nettype wire

// file: tb/svbk_host_model.sv
// Purpose: host side of the register access strobes
// Assumes: requests launched on the falling edge
// Notes: idle bus shows the inverted last address; write data is inverted only after a write, a read leaves it stale
`timescale 1ns/10ps
`default_nettype none
module svbk_host_model (
  // clock
  input wire logic mclk_in,
  // register access
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in
);
  initial
  begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    wr_en_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(negedge mclk_in);
    wr_en_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  // answer is due exactly one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_in);
    rd_en_out = 1'b1;
    addr_out = a;
    @(negedge mclk_in);
    rd_en_out = 1'b0;
    addr_out = ~a;
    d = rvalid_in ? rdata_in : 8'hXX;
  endtask
endmodule
`default_nettype wire

// file: tb/test_supervisor_bank1_control_regs.sv
// Purpose: register and pin tests of the bank-one register file
// Assumes: host model drives the access strobes
// Notes: expected values built from offsets and patterns
`timescale 1ns/10ps
`default_nettype none
module test_supervisor_bank1_control_regs;
  logic mclk_in = 1'b0, sys_rst_in, wr_en_in, rd_en_in, rvalid_out;
  logic [7:0] addr_in, wdata_in, rdata_out, d, ch3_cutoff_out;
  logic [7:0] ch4_debounce_out, watchdog_violation_config_out, esm_time_out;
  logic wdog_latched_in, irq_req_in, shutdown_in, por_done_in;
  logic watchdog_fault_out_n, interrupt_out_n, packet_check_enable;
  logic packet_check_required, protect_clear_out, self_test_start_out;
  logic [2:0] ramp_up_in, above_up_thld_in, watchdog_fault_hold_delay;
  logic [2:0] fast_uv_irq_en_out, slow_uv_irq_en_out;
  logic [2:0] supply_transition_mask, ramp_down_in, below_dn_thld_in;
  logic [15:0] seq_timeout_out;
  logic [7:0] ch4_cutoff_out;
  logic [7:0] offs [10] = '{8'h10, 8'h11, 8'h13, 8'h14, 8'h45, 8'h54,
    8'h9E, 8'hAA, 8'hF0, 8'h55};
  int bad_count = 0, comparisons = 0, hits;
  always #20 mclk_in = ~mclk_in;
  svbk_host_model host (.mclk_in, .wr_en_out(wr_en_in),
    .rd_en_out(rd_en_in), .addr_out(addr_in), .wdata_out(wdata_in),
    .rdata_in(rdata_out), .rvalid_in(rvalid_out));
  svbk_bank1_regs dut (.mclk_in, .sys_rst_in, .wr_en_in, .rd_en_in,
    .addr_in, .wdata_in, .rdata_out, .rvalid_out, .wdog_fault_in(1'b0),
    .wdog_latched_in, .irq_req_in, .shutdown_in, .por_done_in,
    .ramp_up_in, .ramp_down_in, .above_up_thld_in,
    .below_dn_thld_in, .watchdog_fault_out_n, .interrupt_out_n,
    .watchdog_fault_hold_delay, .packet_check_enable,
    .packet_check_required, .protect_clear_out, .self_test_start_out,
    .fast_uv_irq_en_out, .slow_uv_irq_en_out, .supply_transition_mask,
    .seq_timeout_out, .ch3_cutoff_out, .ch4_cutoff_out,
    .ch4_debounce_out, .watchdog_violation_config_out, .esm_time_out);
  task automatic chk(input string n, input logic [15:0] got,
    input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, exp, got);
    end
  endtask
  // pulses may land one or two cycles late, so a short window is scanned
  task automatic scan(input bit st);
    hits = 0;
    repeat (4)
    begin
      hits += int'((st ? self_test_start_out : protect_clear_out) === 1'b1);
      @(negedge mclk_in);
    end
  endtask
  task automatic wait2;
    repeat (2) @(negedge mclk_in);
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge mclk_in);
    bad_count++;
    print_verdict();
  end
  // ==========================================================
  // tests
  initial
  begin
    {sys_rst_in, wdog_latched_in, irq_req_in, shutdown_in} = 4'h8;
    {por_done_in, ramp_up_in, above_up_thld_in} = 7'h00;
    {ramp_down_in, below_dn_thld_in} = 6'h00;
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    sys_rst_in = 1'b0;
    foreach (offs[i])
    begin
      host.rd(offs[i], d);
      chk("reset", d, i ? 8'h00 : 8'h20);
      host.wr(offs[i], offs[i] ^ 8'h5A);
    end
    host.wr(8'h15, 8'hFF);
    host.rd(8'h15, d);
    chk("unmapped", d, 8'h00);
    foreach (offs[i])
    begin
      host.rd(offs[i], d);
      chk("readback", d, (offs[i] ^ 8'h5A) & (i ? 8'hFF : 8'hF7));
    end
    chk("cutoff", ch3_cutoff_out, 8'h45 ^ 8'h5A);
    chk("cutoff4", ch4_cutoff_out, 8'h55 ^ 8'h5A);
    chk("debounce", ch4_debounce_out, 8'h54 ^ 8'h5A);
    chk("watchdog_violation_config", watchdog_violation_config_out, 8'hAA ^ 8'h5A);
    chk("esm", esm_time_out, 8'h9E ^ 8'h5A);
    host.wr(8'h10, 8'h11);
    wait2();
    chk("wdog pin", watchdog_fault_out_n, 1'b0);
    chk("irq pin", interrupt_out_n, 1'b0);
    host.wr(8'h10, 8'h20);
    irq_req_in = 1'b1;
    wait2();
    chk("wdog pin", watchdog_fault_out_n, 1'b1);
    chk("irq pin", interrupt_out_n, 1'b0);
    irq_req_in = 1'b0;
    host.wr(8'h10, 8'h08);
    scan(1'b0);
    chk("clear pulse", hits, 1);
    for (int p = 0; p < 4; p++)
    begin
      host.wr(8'h11, 8'h50 | p);
      wait2();
      chk("pec", {packet_check_required, packet_check_enable}, p);
    end
    chk("delay", watchdog_fault_hold_delay, 3'h5);
    wdog_latched_in = 1'b1;
    wait2();
    chk("delay latched", watchdog_fault_hold_delay, 3'h0);
    host.wr(8'h13, 8'hF5);
    host.wr(8'h14, 8'h0A);
    wait2();
    chk("fast uv", fast_uv_irq_en_out, 3'b010);
    chk("slow uv", slow_uv_irq_en_out, 3'b101);
    for (int k = 0; k < 3; k++)
    begin
      host.wr(8'h12, k == 2 ? 8'h04 : 8'h00);
      wait2();
      shutdown_in = ~shutdown_in;
      scan(1'b1);
      chk("shutdown test", hits, k == 2);
    end
    host.wr(8'h12, 8'h02);
    por_done_in = 1'b1;
    scan(1'b1);
    chk("por test", hits, 1);
    host.wr(8'hA5, 8'h12);
    host.wr(8'hA6, 8'h34);
    host.wr(8'hA1, 8'hFF);
    ramp_up_in = 3'h7;
    wait2();
    chk("timeout", seq_timeout_out, 16'h1234);
    chk("mask", supply_transition_mask, 3'h7);
    above_up_thld_in = 3'h7;
    wait2();
    chk("mask off", supply_transition_mask, 3'h0);
    host.wr(8'hA2, 8'h0A);
    ramp_down_in = 3'h7;
    wait2();
    chk("mask dn", supply_transition_mask, 3'h5);
    below_dn_thld_in = 3'h7;
    wait2();
    chk("mask dn off", supply_transition_mask, 3'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
